// [hdl/ifp_regs.svh]
/*
  constants of the fetch/execute pipeline: widths, reset values,
  instruction field positions, opcodes and clock source codes.
  assumes: included by bare name from the package and the design modules.
*/
`ifndef IFP_REGS_SVH
`define IFP_REGS_SVH

// ========================================
// widths
`define IFP_PC_W        14          // 16k-word program space
`define IFP_IW          16          // instruction word width
`define IFP_DW          8           // alu / accumulator width
`define IFP_NPH         4           // phases per machine cycle

// ========================================
// reset values
`define IFP_PC_RST      14'h0000    // reset vector
`define IFP_ACC_RST     8'h00
`define IFP_NOP_WORD    16'h0000    // word placed in a flushed slot
`define IFP_PH_RST      4'h1        // first phase active after reset
`define IFP_OSC_RST     2'h2        // fast internal oscillator

// ========================================
// instruction fields
`define IFP_OPC_HI      15
`define IFP_OPC_LO      12
`define IFP_IMM_HI      7
`define IFP_TGT_HI      11
`define IFP_PAGE_LO     8           // pc low byte spans one 256-word page

// ========================================
// opcodes
`define IFP_OP_NOP      4'h0
`define IFP_OP_MOVI     4'h1
`define IFP_OP_ADD      4'h2
`define IFP_OP_SUB      4'h3
`define IFP_OP_AND      4'h4
`define IFP_OP_OR       4'h5
`define IFP_OP_XOR      4'h6
`define IFP_OP_RR       4'h7
`define IFP_OP_INC      4'h8
`define IFP_OP_DEC      4'h9
`define IFP_OP_JMP      4'ha
`define IFP_OP_CALL     4'hb
`define IFP_OP_SZA      4'hc
`define IFP_OP_WPCL     4'hd
`define IFP_OP_LADD     4'he        // extended: two machine cycles

// ========================================
// main clock source codes
`define IFP_OSC_FXT     2'h0        // fast_crystal_osc
`define IFP_OSC_SXT     2'h1        // slow_crystal_osc
`define IFP_OSC_FIRC    2'h2        // fast_internal_osc
`define IFP_OSC_SIRC    2'h3        // slow_internal_osc

`endif

// [hdl/ifp_pkg.sv]
/*
  types of the fetch/execute pipeline: phase and instruction class enums.
  assumes: ifp_regs.svh is reachable on the include path.
*/
package ifp_pkg;
  `include "ifp_regs.svh"

  // ========================================
  // phase of the machine cycle
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} ifp_phase_e;

  // ========================================
  // decoded instruction class
  typedef enum logic [2:0] {CLS_NOP, CLS_ALU, CLS_BRANCH, CLS_SKIP, CLS_PCL,
                            CLS_EXT} ifp_cls_e;
endpackage

// [hdl/ifp_phase_if.sv]
/*
  carrier between the phase generator and the pipeline core.
  assumes: both ends sit on the same clock.
*/
`timescale 1ns/1ns
interface ifp_phase_if;
  import ifp_pkg::*;
  ifp_phase_e  phase;                 // current phase
  logic [3:0]  phase_clks;            // one-hot phase clocks, registered

  modport gen  (output phase, output phase_clks);
  modport core (input  phase, input  phase_clks);
endinterface

// [hdl/ifp_phase_gen.sv]
/*
  splits the system clock into four non-overlapping one-hot phases.
  assumes: synchronous active-low reset; one phase per clock.
*/
`timescale 1ns/1ns
`include "ifp_regs.svh"
module ifp_phase_gen
  import ifp_pkg::*;
(
  input  wire logic i_clk,            // system clock
  input  wire logic i_rst_n,          // sync reset, active low
  ifp_phase_if.gen  ph                // phase outputs
);
  // ========================================
  // phase sequencer
  ifp_phase_e  ph_ff;                 // current phase
  ifp_phase_e  nxt_ph;
  logic [3:0]  clks_ff;               // one-hot phase clocks
  logic [3:0]  nxt_clks;

  // next phase and its one-hot pattern
  always_comb begin
    case (ph_ff)
      PH_T1:   nxt_ph = PH_T2;
      PH_T2:   nxt_ph = PH_T3;
      PH_T3:   nxt_ph = PH_T4;
      PH_T4:   nxt_ph = PH_T1;        // RULE4
      default: nxt_ph = PH_T1;
    endcase
    nxt_clks = 4'h1 << nxt_ph;        // RULE1
  end

  // registers only
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ph_ff   <= PH_T1;
      clks_ff <= `IFP_PH_RST;
    end else begin
      ph_ff   <= nxt_ph;
      clks_ff <= nxt_clks;
    end
  end

  assign ph.phase      = ph_ff;
  assign ph.phase_clks = clks_ff;
endmodule

// [hdl/ifp_pipeline.sv]
/*
  fetch/execute pipeline of a small 8-bit core: phase-sequenced fetch,
  decode, alu and writeback, with prefetch flush on control transfer.
  assumes: program memory answers combinationally on i_fetch_data in the
  same clock as o_fetch_addr; the clock source mux sits outside.
*/
// Functional notes
// RULE1 - four non-overlapping phases make one cycle
// RULE2 - pc advances and fetches in first phase
// RULE3 - decode and execute in phases two-four
// RULE4 - one pass of four phases, one cycle
// RULE5 - fetch next while executing current instruction
// RULE6 - standard one cycle, extended two cycles
// RULE7 - pc change discards prefetch, adds cycle
// RULE8 - branch: get target, then transfer control
// RULE9 - eight-bit alu for all operations
// RULE10 - data moves through accumulator and alu
// RULE11 - clock from one of four oscillators
// RULE12 - taken skip discards prefetch, dummy cycle
// RULE13 - pc low write jumps in page
// RULE14 - flushed slot runs as no-operation
`timescale 1ns/1ns
`include "ifp_regs.svh"
module ifp_pipeline
  import ifp_pkg::*;
(
  input  wire logic                  i_clk,        // system clock, 10 MHz
  input  wire logic                  i_rst_n,      // sync reset, active low
  input  wire logic [1:0]            i_osc_sel,    // requested clock source
  input  wire logic [`IFP_IW-1:0]    i_fetch_data, // program memory word
  output logic      [1:0]            o_osc_sel,    // applied clock source
  output logic      [3:0]            o_phase_clks, // instruction_phase_clocks
  output logic      [`IFP_PC_W-1:0]  o_fetch_addr, // program counter
  output logic                       o_fetch_en,   // fetch in this phase
  output logic      [`IFP_DW-1:0]    o_acc,        // accumulator
  output logic                       o_zero,       // accumulator is zero
  output logic                       o_retire,     // instruction completed
  output logic                       o_flush,      // prefetch discarded
  output logic                       o_branch      // control transferred
);
  // ========================================
  // phase generator
  ifp_phase_if ph ();                // phase carrier

  ifp_phase_gen u_phase (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .ph      (ph)
  );

  // ========================================
  // helpers

  // opcode to instruction class
  function automatic ifp_cls_e decode(input logic [3:0] op);
    case (op)
      `IFP_OP_JMP, `IFP_OP_CALL: decode = CLS_BRANCH;
      `IFP_OP_SZA:               decode = CLS_SKIP;
      `IFP_OP_WPCL:              decode = CLS_PCL;
      `IFP_OP_LADD:              decode = CLS_EXT;
      `IFP_OP_NOP:               decode = CLS_NOP;
      default:                   decode = CLS_ALU;
    endcase
  endfunction

  // eight-bit alu
  function automatic logic [`IFP_DW-1:0] alu(input logic [3:0]         op,
                                             input logic [`IFP_DW-1:0] a,
                                             input logic [`IFP_DW-1:0] b);
    case (op)
      `IFP_OP_MOVI:              alu = b;
      `IFP_OP_ADD, `IFP_OP_LADD: alu = a + b;
      `IFP_OP_SUB:               alu = a - b;
      `IFP_OP_AND:               alu = a & b;
      `IFP_OP_OR:                alu = a | b;
      `IFP_OP_XOR:               alu = a ^ b;
      `IFP_OP_RR:                alu = {a[0], a[`IFP_DW-1:1]};
      `IFP_OP_INC:               alu = a + 8'h01;
      `IFP_OP_DEC:               alu = a - 8'h01;
      default:                   alu = a;
    endcase
  endfunction

  // ========================================
  // pipeline state
  logic [`IFP_PC_W-1:0] pc_ff,     nxt_pc;      // program counter
  logic [`IFP_IW-1:0]   pf_ff,     nxt_pf;      // prefetched word
  logic [`IFP_IW-1:0]   ir_ff,     nxt_ir;      // executing word
  ifp_cls_e             cls_ff,    nxt_cls;     // decoded class
  logic [`IFP_PC_W-1:0] tgt_ff,    nxt_tgt;     // branch target
  logic [`IFP_DW-1:0]   res_ff,    nxt_res;     // alu result
  logic [`IFP_DW-1:0]   acc_ff,    nxt_acc;     // accumulator
  logic                 flush_ff,  nxt_flush;   // discard next prefetch
  logic                 bubble_ff, nxt_bubble;  // slot is a flushed nop
  logic                 hold_ff,   nxt_hold;    // extended: refetch held
  logic                 second_ff, nxt_second;  // extended: second pass
  logic                 ret_ff,    nxt_ret;     // retire pulse
  logic                 fl_ff,     nxt_fl;      // flush pulse
  logic                 br_ff,     nxt_br;      // branch pulse
  logic                 fen_ff,    nxt_fen;     // fetch enable
  logic                 zero_ff,   nxt_zero;    // accumulator is zero

  logic [3:0]           op;                     // opcode of executing word
  logic [`IFP_DW-1:0]   imm;                    // immediate byte

  assign op  = ir_ff[`IFP_OPC_HI:`IFP_OPC_LO];
  assign imm = ir_ff[`IFP_IMM_HI:0];

  // next pipeline values, one stage per phase
  always_comb begin
    nxt_pc     = pc_ff;
    nxt_pf     = pf_ff;
    nxt_ir     = ir_ff;
    nxt_cls    = cls_ff;
    nxt_tgt    = tgt_ff;
    nxt_res    = res_ff;
    nxt_acc    = acc_ff;
    nxt_flush  = flush_ff;
    nxt_bubble = bubble_ff;
    nxt_hold   = hold_ff;
    nxt_second = second_ff;
    nxt_ret    = 1'b0;
    nxt_fl     = 1'b0;
    nxt_br     = 1'b0;
    case (ph.phase)
      // fetch stage
      PH_T1: begin
        if (hold_ff) begin                  // extended: keep word, no fetch
          nxt_hold   = 1'b0;                // RULE6
          nxt_second = 1'b1;
        end else begin
          nxt_pc     = pc_ff + 14'h0001;    // RULE2
          nxt_pf     = i_fetch_data;        // RULE5
          nxt_ir     = flush_ff ? `IFP_NOP_WORD : pf_ff; // RULE14
          nxt_bubble = flush_ff;            // RULE7
          nxt_flush  = 1'b0;
          nxt_second = 1'b0;
        end
      end
      // decode stage, target captured here
      PH_T2: begin
        nxt_cls = decode(op);               // RULE3
        nxt_tgt = {pc_ff[`IFP_PC_W-1:`IFP_TGT_HI+1],
                   ir_ff[`IFP_TGT_HI:0]};   // RULE8
        if (decode(op) == CLS_PCL) begin
          nxt_tgt = {pc_ff[`IFP_PC_W-1:`IFP_PAGE_LO], imm}; // RULE13
        end
      end
      // alu stage
      PH_T3: begin
        nxt_res = alu(op, acc_ff, imm);     // RULE9
      end
      // writeback and control transfer
      PH_T4: begin
        case (cls_ff)
          CLS_ALU: begin
            nxt_acc = res_ff;               // RULE10
            nxt_ret = 1'b1;
          end
          CLS_EXT: begin
            if (second_ff) begin
              nxt_acc = res_ff;             // RULE6
              nxt_ret = 1'b1;
            end else begin
              nxt_hold = 1'b1;              // RULE6
            end
          end
          CLS_BRANCH, CLS_PCL: begin
            nxt_pc    = tgt_ff;             // RULE8
            nxt_flush = 1'b1;               // RULE7
            nxt_fl    = 1'b1;
            nxt_br    = 1'b1;
            nxt_ret   = 1'b1;
          end
          CLS_SKIP: begin
            nxt_flush = (acc_ff == 8'h00);  // RULE12
            nxt_fl    = (acc_ff == 8'h00);
            nxt_ret   = 1'b1;
          end
          CLS_NOP: begin
            nxt_ret = !bubble_ff;           // RULE14
          end
          default: begin
            nxt_ret = 1'b0;
          end
        endcase
      end
      default: begin
        nxt_ret = 1'b0;
      end
    endcase
    nxt_fen = (ph.phase == PH_T4) && !nxt_hold; // RULE2
    // zero flag tracks the accumulator in the same cycle
    nxt_zero = (nxt_acc == 8'h00);          // RULE10
  end

  // registers only
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pc_ff     <= `IFP_PC_RST;
      pf_ff     <= `IFP_NOP_WORD;
      ir_ff     <= `IFP_NOP_WORD;
      cls_ff    <= CLS_NOP;
      tgt_ff    <= `IFP_PC_RST;
      res_ff    <= `IFP_ACC_RST;
      acc_ff    <= `IFP_ACC_RST;
      flush_ff  <= 1'b1;                    // first slot after reset is empty
      bubble_ff <= 1'b1;                    // pipeline empty after reset
      hold_ff   <= 1'b0;
      second_ff <= 1'b0;
      ret_ff    <= 1'b0;
      fl_ff     <= 1'b0;
      br_ff     <= 1'b0;
      fen_ff    <= 1'b1;                    // first phase is a fetch
      zero_ff   <= 1'b1;                    // accumulator resets to zero
    end else begin
      pc_ff     <= nxt_pc;
      pf_ff     <= nxt_pf;
      ir_ff     <= nxt_ir;
      cls_ff    <= nxt_cls;
      tgt_ff    <= nxt_tgt;
      res_ff    <= nxt_res;
      acc_ff    <= nxt_acc;
      flush_ff  <= nxt_flush;
      bubble_ff <= nxt_bubble;
      hold_ff   <= nxt_hold;
      second_ff <= nxt_second;
      ret_ff    <= nxt_ret;
      fl_ff     <= nxt_fl;
      br_ff     <= nxt_br;
      fen_ff    <= nxt_fen;
      zero_ff   <= nxt_zero;
    end
  end

  // ========================================
  // clock source select
  logic [1:0] osc_s1_ff, osc_s2_ff, osc_ff;     // sync stages, applied
  logic [1:0] nxt_osc;

  // change source only at a cycle boundary so no phase is cut short
  always_comb begin
    nxt_osc = osc_ff;
    if (ph.phase == PH_T4) begin
      nxt_osc = osc_s2_ff;                  // RULE11
    end
  end

  // registers only
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_s1_ff <= `IFP_OSC_RST;
      osc_s2_ff <= `IFP_OSC_RST;
      osc_ff    <= `IFP_OSC_RST;
    end else begin
      osc_s1_ff <= i_osc_sel;
      osc_s2_ff <= osc_s1_ff;
      osc_ff    <= nxt_osc;
    end
  end

  // ========================================
  // outputs, all from flops
  assign o_osc_sel    = osc_ff;
  assign o_phase_clks = ph.phase_clks;      // RULE1
  assign o_fetch_addr = pc_ff;
  assign o_fetch_en   = fen_ff;
  assign o_acc        = acc_ff;
  assign o_zero       = zero_ff;
  assign o_retire     = ret_ff;
  assign o_flush      = fl_ff;
  assign o_branch     = br_ff;
endmodule

// [sim/ifp_pipeline_assertions.sv]
/*
  concurrent checks on the fetch/execute pipeline top ports.
  assumes: bound onto ifp_pipeline; one clock, sync active-low reset.
*/
`timescale 1ns/1ns
`include "ifp_regs.svh"
module ifp_pipeline_assertions (
  input wire logic                 i_clk,        // system clock
  input wire logic                 i_rst_n,      // sync reset, active low
  input wire logic [1:0]           i_osc_sel,    // requested source
  input wire logic [`IFP_IW-1:0]   i_fetch_data, // program word
  input wire logic [1:0]           o_osc_sel,    // applied source
  input wire logic [3:0]           o_phase_clks, // one-hot phases
  input wire logic [`IFP_PC_W-1:0] o_fetch_addr, // program counter
  input wire logic                 o_fetch_en,   // fetch strobe
  input wire logic [`IFP_DW-1:0]   o_acc,        // accumulator
  input wire logic                 o_zero,       // acc zero flag
  input wire logic                 o_retire,     // completion pulse
  input wire logic                 o_flush,      // prefetch discarded
  input wire logic                 o_branch      // pc loaded
);
  // ========================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_phase_onehot: assert property ($onehot(o_phase_clks))
    else $error("phase clocks not one-hot");
  a_phase_order: assert property (o_phase_clks[0] |=> o_phase_clks[1] ##1
    o_phase_clks[2] ##1 o_phase_clks[3] ##1 o_phase_clks[0])
    else $error("phase order broken");
  a_fetch_t1: assert property (o_fetch_en |-> o_phase_clks[0])
    else $error("fetch outside first phase");
  a_pc_advance: assert property (o_fetch_en |=>
    o_fetch_addr == $past(o_fetch_addr) + 14'h1)
    else $error("pc not advanced after fetch");
  a_addr_hold: assert property ((o_phase_clks[1] || o_phase_clks[2]) |=>
    $stable(o_fetch_addr))
    else $error("pc moved mid cycle");
  a_retire_t1: assert property (o_retire |-> o_phase_clks[0])
    else $error("retire outside first phase");
  a_bubble_noretire: assert property (o_flush |-> ##4 !o_retire)
    else $error("flush bubble retired");
  a_bubble_acc: assert property (o_flush |=> $stable(o_acc)[*4])
    else $error("acc changed in bubble");
  a_branch_flush: assert property (o_branch |-> o_flush)
    else $error("branch without flush");
  a_zero_flag: assert property (o_zero == (o_acc == 8'h00))
    else $error("zero flag wrong");
  a_osc_t4: assert property (!$stable(o_osc_sel) |-> $past(o_phase_clks[3]))
    else $error("clock source switched off cycle end");
endmodule

bind ifp_pipeline ifp_pipeline_assertions u_chk (.i_clk, .i_rst_n, .i_osc_sel,
  .i_fetch_data, .o_osc_sel, .o_phase_clks, .o_fetch_addr, .o_fetch_en, .o_acc,
  .o_zero, .o_retire, .o_flush, .o_branch);

// [sim/test_ifp_pipeline.sv]
/*
  self-checking bench for the fetch/execute pipeline.
  assumes: program memory modelled as a combinational table on o_fetch_addr.
*/
`timescale 1ns/1ns
`include "ifp_regs.svh"
module test_ifp_pipeline;
  // ========================================
  // stimulus and wiring
  logic        i_clk = 1'b0;   // 100 ns clock
  logic        i_rst_n = 1'b0; // held low at start
  logic [1:0]  i_osc_sel = 2'h2; // requested source
  wire  [15:0] i_fetch_data;   // memory answer
  logic [1:0]  o_osc_sel;
  logic [3:0]  o_phase_clks;
  logic [13:0] o_fetch_addr;
  logic        o_fetch_en, o_zero, o_retire, o_flush, o_branch;
  logic [7:0]  o_acc;
  logic [15:0] mem [0:255];    // program store
  int          err_total = 0;
  int          n_checks = 0;
  logic [3:0]  aop [9] = '{`IFP_OP_MOVI, `IFP_OP_ADD, `IFP_OP_SUB, `IFP_OP_AND,
    `IFP_OP_OR, `IFP_OP_XOR, `IFP_OP_RR, `IFP_OP_INC, `IFP_OP_DEC};
  logic [7:0]  aim [9] = '{8'h5a, 8'h13, 8'h01, 8'hf0, 8'h03, 8'hff, 8'h00, 8'h00, 8'h00};
  logic [7:0]  aex [9] = '{8'h5a, 8'h6d, 8'h6c, 8'h60, 8'h63, 8'h9c, 8'h4e, 8'h4f, 8'h4e};

  always #50 i_clk = ~i_clk;
  assign i_fetch_data = mem[o_fetch_addr[7:0]]; // same-clock answer

  ifp_pipeline uut (.i_clk, .i_rst_n, .i_osc_sel, .i_fetch_data, .o_osc_sel,
    .o_phase_clks, .o_fetch_addr, .o_fetch_en, .o_acc, .o_zero, .o_retire,
    .o_flush, .o_branch);

  // ========================================
  // helpers
  function automatic logic [15:0] w(input logic [3:0] op, input logic [7:0] v);
    return {op, 4'h0, v};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge i_clk);
    #1;
  endtask
  // clears memory to no-operation words; rst pulses reset for two clocks
  task boot;
    foreach (mem[i]) mem[i] = `IFP_NOP_WORD;
  endtask
  task rst;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1;
  endtask
  // sel 0 waits for retire, 1 for flush; n is clocks waited
  task wait_on(input int sel, output int n);
    n = 0;
    do begin
      step;
      n++;
    end while (((sel == 0) ? o_retire : o_flush) !== 1'b1 && n < 60);
    if (n >= 60) begin
      err_total++;
      finish_test;
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ========================================
  // scenarios
  // reset state, then every alu op back to back
  task t_alu;
    int n;
    boot;
    for (int k = 0; k < 9; k++) mem[k] = w(aop[k], aim[k]);
    rst;
    chk(o_phase_clks, 16'h1);
    chk(o_fetch_addr, 16'h0);
    chk(o_osc_sel, 16'h2);
    for (int k = 0; k < 9; k++) begin
      wait_on(0, n);
      chk(o_acc, aex[k]);
      if (k > 0) chk(16'(n), 16'h4);
    end
  endtask
  // control transfer: flush, target fetch, bubble, target result
  task t_br(input logic [3:0] op, input logic [7:0] a0, input logic b,
            input logic [13:0] tgt);
    int n;
    boot;
    mem[0] = w(`IFP_OP_MOVI, a0);
    mem[1] = w(op, 8'h20);
    mem[2] = w(`IFP_OP_MOVI, 8'hee); // must be discarded
    mem[3] = w(`IFP_OP_MOVI, 8'h77);
    mem[8'h20] = w(`IFP_OP_MOVI, 8'h77);
    rst;
    wait_on(1, n);
    chk(o_branch, b);
    chk(o_fetch_addr, tgt);
    chk(o_acc, a0);
    chk(o_zero, 16'(a0 == 8'h00));
    wait_on(0, n);
    chk(16'(n), 16'h8);
    chk(o_acc, 16'h77);
  endtask
  // skip not taken: no flush, next word runs
  task t_noskip;
    int n;
    boot;
    mem[0] = w(`IFP_OP_MOVI, 8'h05);
    mem[1] = w(`IFP_OP_SZA, 8'h00);
    mem[2] = w(`IFP_OP_MOVI, 8'h11);
    rst;
    repeat (2) wait_on(0, n);
    chk(o_flush, 16'h0);
    wait_on(0, n);
    chk(16'(n), 16'h4);
    chk(o_acc, 16'h11);
  endtask
  // extended op takes two cycles
  task t_ladd;
    int n;
    boot;
    mem[0] = w(`IFP_OP_MOVI, 8'h10);
    mem[1] = w(`IFP_OP_LADD, 8'h05);
    mem[2] = w(`IFP_OP_MOVI, 8'h99);
    rst;
    wait_on(0, n);
    wait_on(0, n);
    chk(16'(n), 16'h8);
    chk(o_acc, 16'h15);
    wait_on(0, n);
    chk(16'(n), 16'h4);
    chk(o_acc, 16'h99);
  endtask
  // every clock source code reaches the applied output
  task t_osc;
    int n;
    for (int c = 0; c < 4; c++) begin
      @(posedge i_clk);
      i_osc_sel <= 2'(c);
      n = 0;
      do begin
        step;
        n++;
      end while (o_osc_sel !== 2'(c) && n < 12);
      chk(o_osc_sel, 16'(c));
      chk(16'(n <= 8), 16'h1);
      if (n >= 12) finish_test;
    end
  endtask

  // ========================================
  // main sequence
  initial begin
    t_alu;
    t_br(`IFP_OP_JMP, 8'h01, 1'b1, 14'h020);
    t_br(`IFP_OP_CALL, 8'h01, 1'b1, 14'h020);
    t_br(`IFP_OP_WPCL, 8'h20, 1'b1, 14'h020);
    t_br(`IFP_OP_SZA, 8'h00, 1'b0, 14'h003);
    t_noskip;
    t_ladd;
    t_osc;
    finish_test;
  end
endmodule
